/* File: src/cmr_defines.svh */
// Constants for the configuration matrix router: source codes, config bit positions, pin modes.
// Assumes the configuration store is a flat 2048-bit vector loaded at start-up and again on each reload pulse.
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH
`define CMR_NUM_SRC         64
`define CMR_NUM_DST         96
`define CMR_SEL_W           6
`define CMR_CFG_BITS        2048
`define CMR_SRC_GND         6'h00
`define CMR_SRC_WIRE0       6'h20
`define CMR_SRC_WIRE1       6'h21
`define CMR_SRC_VIRT_LO     6'h22
`define CMR_SRC_DLY_EDGE    6'h2A
`define CMR_SRC_FLT_EDGE    6'h2B
`define CMR_SRC_INPUT_ONLY  6'h2C
`define CMR_SRC_GPIO2       6'h2D
`define CMR_SRC_OSC_A       6'h35
`define CMR_SRC_FAST_CMP    6'h38
`define CMR_SRC_SLOW_CMP    6'h3A
`define CMR_SRC_OSC_B       6'h3C
`define CMR_SRC_POR         6'h3E
`define CMR_SRC_VDD         6'h3F
`define CMR_BIT_FAST_PULL   778
`define CMR_BIT_WIRE0_OD    790
`define CMR_BIT_WIRE1_OD    796
`define CMR_BIT_LINK_EN     2032
`define CMR_BIT_VIRT0       608
`define CMR_BIT_WIRE0_MODE  784
`define CMR_BIT_WIRE1_MODE  792
`define CMR_VIRT_REG_ADDR   8'h4C
`define CMR_FAST_PULL_CYC   16
`endif

/* File: src/cmr_pkg.sv */
// Types shared by the router and its selector.
// Assumes cmr_defines.svh is on the include path.
`default_nettype none
`include "cmr_defines.svh"
package cmr_pkg;
    typedef logic [`CMR_SEL_W-1:0] cmr_sel_t;   // One destination select field
    typedef enum logic [1:0] {
        CMR_IN_PLAIN   = 2'h0,                  // Input without hysteresis
        CMR_IN_SCHMITT = 2'h1,                  // Input with hysteresis
        CMR_IN_LOWV    = 2'h2,                  // Low-voltage input
        CMR_IN_RSVD    = 2'h3                   // Reserved
    } cmr_in_mode_t;
    typedef enum logic [1:0] {
        CMR_PULL_10K  = 2'h0,
        CMR_PULL_100K = 2'h1,
        CMR_PULL_1M   = 2'h2,
        CMR_PULL_NONE = 2'h3
    } cmr_pull_val_t;
    typedef enum logic [2:0] {
        CMR_ST_LOAD = 3'b001,                   // Waiting for the store to load
        CMR_ST_FAST = 3'b010,                   // Strong pull phase of power-up
        CMR_ST_RUN  = 3'b100                    // Normal operation
    } cmr_state_t;
endpackage : cmr_pkg
`default_nettype wire

/* File: src/cmr_sel64.sv */
// One 64-to-1 source selector for a single destination line.
// Assumes the select field is stable except across a store reload.
`default_nettype none
`include "cmr_defines.svh"
module cmr_sel64 (
    input  wire logic [`CMR_NUM_SRC-1:0] src_i,   // All source lines
    input  wire cmr_pkg::cmr_sel_t       sel_i,   // Binary source code
    output logic                         dst_o    // Chosen source level
);
    import cmr_pkg::*;
    // Full binary decode: every code names a source, so no code is undefined
    assign dst_o = src_i[sel_i];
endmodule // cmr_sel64
`default_nettype wire

/* File: src/cmr_router.sv */
// Configuration matrix router with pin configuration for a small OTP mixed-signal part.
// Assumes macrocell outputs and pin input levels arrive synchronous to clk_i.
//
// Contract
// - Sixty-four sources feed ninety-six destination lines.
// - Each destination uses own six-bit selector field.
// - A 2048-bit loaded store defines everything.
// - Each source hard-wired, level passed unchanged.
// - Codes 32/33 give wire pins or virtuals.
// - Codes 42/43 give delay and filter edges.
// - Codes 56-59 give fast then slow comparators.
// - Ten two-way pins, one input, one output.
// - Pulls 10k/100k/1M, up or down selectable.
// - Bit 778 gives strong pull at power-up.
// - Wire pin input mode field encoding.
// - Bits 790/796 make wire pins open-drain.
// - Wire pins never drive high.
// - Wire pin enable from fixed config bit.
// - Wire pin received level is a source.
// - Virtual bits reachable by link at 0x4C.
// - Bit 2032 picks pins or virtual bits.
`default_nettype none
`include "cmr_defines.svh"
module cmr_router #(
    parameter int FAST_PULL_CYC = `CMR_FAST_PULL_CYC    // Strong-pull duration in cycles
) (
    input  wire logic                            clk_i,            // System clock
    input  wire logic                            rst_i,            // Sync reset, active high
    input  wire logic [`CMR_CFG_BITS-1:0]        cfg_data_i,       // Nonvolatile store contents
    input  wire logic                            cfg_load_i,       // Pulse: take store contents
    input  wire logic [31:1]                     lut_out_i,        // Logic cell outputs, codes 1..31
    input  wire logic                            ripple_out2_i,    // Code 40
    input  wire logic                            lut4_out_i,       // Code 41
    input  wire logic                            dly_edge_i,       // Delay edge-detect output
    input  wire logic                            flt_edge_i,       // Filter edge-detect output
    input  wire logic                            input_only_pin_i, // Input-only pin level
    input  wire logic [9:2]                      gpio_in_i,        // Two-way pins 2..9 levels
    input  wire logic [1:0]                      wire_pin_in_i,    // Two-wire pins received level
    input  wire logic [2:0]                      osc_out_a_i,      // Oscillator first outputs
    input  wire logic [1:0]                      osc_out_b_i,      // Oscillator second outputs
    input  wire logic [1:0]                      fast_comparator_i,// High-speed comparators
    input  wire logic [1:0]                      slow_comparator_i,// Low-power comparators
    input  wire logic                            por_i,            // Power-on reset output
    input  wire logic                            virt_wr_i,        // Link write strobe
    input  wire logic [7:0]                      virt_addr_i,      // Link register byte
    input  wire logic [7:0]                      virt_wdata_i,     // Link write data
    output logic      [7:0]                      virt_rdata_o,     // Link read data
    output logic      [`CMR_NUM_DST-1:0]         dst_o,            // Destination lines
    output logic                                 cfg_valid_o,      // Store loaded
    output logic      [1:0]                      wire_pin_out_o,   // Two-wire pin output level
    output logic      [1:0]                      wire_pin_oe_n_o,  // Two-wire pin enable, low drives
    output cmr_pkg::cmr_in_mode_t                wire0_mode_o,     // Input mode, pin 0
    output cmr_pkg::cmr_in_mode_t                wire1_mode_o,     // Input mode, pin 1
    output logic      [11:0]                     pull_up_o,        // Pull direction per pin
    output cmr_pkg::cmr_pull_val_t [11:0]        pull_val_o,       // Pull strength per pin
    output logic                                 fast_pull_o       // Strong pull active
);
    import cmr_pkg::*;

    localparam int PIN_CFG_BASE = 1000;            // Start of per-pin pull fields
    localparam int PIN_CFG_W    = 3;               // Up/down bit plus two value bits

    logic [`CMR_CFG_BITS-1:0] cfg_reg;             // Loaded configuration store
    logic [7:0]               virt_reg;            // Virtual source bits
    cmr_state_t               state_reg;           // Power-up sequencer
    logic [15:0]              fast_cnt_reg;        // Strong-pull timer
    logic [`CMR_NUM_SRC-1:0]  src;                 // Source lines

    // Pull one select field out of the store
    function automatic cmr_sel_t sel_field(input logic [`CMR_CFG_BITS-1:0] c, input int d);
        sel_field = c[d*`CMR_SEL_W +: `CMR_SEL_W];
    endfunction

    // Store loads only on the load pulse; apart from reset clearing it, nothing else writes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= '0;
        end else if (cfg_load_i) begin
            cfg_reg <= cfg_data_i;
        end
    end

    // Virtual bits start from the store and follow later link writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            virt_reg <= 8'h00;
        end else if (cfg_load_i) begin
            virt_reg <= cfg_data_i[`CMR_BIT_VIRT0 +: 8];
        end else if (virt_wr_i && virt_addr_i == `CMR_VIRT_REG_ADDR) begin
            virt_reg <= virt_wdata_i;
        end
    end

    // Read data is registered; other addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            virt_rdata_o <= 8'h00;
        end else begin
            virt_rdata_o <= (virt_addr_i == `CMR_VIRT_REG_ADDR) ? virt_reg : 8'h00;
        end
    end

    // Power-up sequencer: strong pull first if enabled, then normal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= CMR_ST_LOAD;
            fast_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                CMR_ST_LOAD: begin
                    if (cfg_load_i) begin
                        fast_cnt_reg <= 16'h0000;
                        state_reg    <= cfg_data_i[`CMR_BIT_FAST_PULL] ? CMR_ST_FAST : CMR_ST_RUN;
                    end
                end
                CMR_ST_FAST: begin
                    fast_cnt_reg <= fast_cnt_reg + 16'h0001;
                    if (fast_cnt_reg == 16'(FAST_PULL_CYC - 1)) begin
                        state_reg <= CMR_ST_RUN;
                    end
                end
                CMR_ST_RUN: begin
                    // A reload restarts the power-up pull sequence
                    if (cfg_load_i) begin
                        fast_cnt_reg <= 16'h0000;
                        state_reg    <= cfg_data_i[`CMR_BIT_FAST_PULL] ? CMR_ST_FAST : CMR_ST_RUN;
                    end
                end
                default: begin
                    state_reg <= CMR_ST_LOAD;
                end
            endcase
        end
    end

    assign cfg_valid_o = (state_reg != CMR_ST_LOAD);
    assign fast_pull_o = (state_reg == CMR_ST_FAST);

    // Hard-wired source map; levels pass through untouched
    always_comb begin
        src                                            = '0;
        src[`CMR_SRC_GND]                              = 1'b0;
        src[31:1]                                      = lut_out_i;
        // Link enable picks virtual bits over the pin levels
        src[`CMR_SRC_WIRE0]   = cfg_reg[`CMR_BIT_LINK_EN] ? virt_reg[0] : wire_pin_in_i[0];
        src[`CMR_SRC_WIRE1]   = cfg_reg[`CMR_BIT_LINK_EN] ? virt_reg[1] : wire_pin_in_i[1];
        src[`CMR_SRC_VIRT_LO +: 6]                     = virt_reg[7:2];
        src[40]                                        = ripple_out2_i;
        src[41]                                        = lut4_out_i;
        src[`CMR_SRC_DLY_EDGE]                         = dly_edge_i;
        src[`CMR_SRC_FLT_EDGE]                         = flt_edge_i;
        src[`CMR_SRC_INPUT_ONLY]                       = input_only_pin_i;
        src[`CMR_SRC_GPIO2 +: 8]                       = gpio_in_i;
        src[`CMR_SRC_OSC_A +: 3]                       = osc_out_a_i;
        src[`CMR_SRC_FAST_CMP +: 2]                    = fast_comparator_i;
        src[`CMR_SRC_SLOW_CMP +: 2]                    = slow_comparator_i;
        src[`CMR_SRC_OSC_B +: 2]                       = osc_out_b_i;
        src[`CMR_SRC_POR]                              = por_i;
        // Code 63 has no printed source; it holds high as a defined constant
        src[`CMR_SRC_VDD]                              = 1'b1;
    end

    // One selector per destination line
    genvar gd;
    generate
        for (gd = 0; gd < `CMR_NUM_DST; gd++) begin : g_dst
            cmr_sel64 u_sel (
                .src_i (src),
                .sel_i (sel_field(cfg_reg, gd)),
                .dst_o (dst_o[gd])
            );
        end
    endgenerate

    // Two-wire pins: only low drive, enable held by config bit
    assign wire_pin_out_o     = 2'b00;
    assign wire_pin_oe_n_o[0] = ~cfg_reg[`CMR_BIT_WIRE0_OD];
    assign wire_pin_oe_n_o[1] = ~cfg_reg[`CMR_BIT_WIRE1_OD];
    assign wire0_mode_o       = cmr_in_mode_t'(cfg_reg[`CMR_BIT_WIRE0_MODE +: 2]);
    assign wire1_mode_o       = cmr_in_mode_t'(cfg_reg[`CMR_BIT_WIRE1_MODE +: 2]);

    // Pull settings for all twelve pins, from per-pin fields
    genvar gp;
    generate
        for (gp = 0; gp < 12; gp++) begin : g_pull
            assign pull_up_o[gp]  = cfg_reg[PIN_CFG_BASE + gp*PIN_CFG_W];
            assign pull_val_o[gp] = cmr_pull_val_t'(cfg_reg[PIN_CFG_BASE + gp*PIN_CFG_W + 1 +: 2]);
        end
    endgenerate

    // Checks
    sel_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dst_o[0] == src[cfg_reg[5:0]]) else $error("dst 0 not source");
    store_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg_load_i |=> $stable(cfg_reg)) else $error("store moved");
    store_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_load_i |=> cfg_reg == $past(cfg_data_i)) else $error("store not loaded");
    link_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_reg[`CMR_BIT_LINK_EN] |-> src[32] == virt_reg[0]) else $error("virtual not chosen");
    pin_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg_reg[`CMR_BIT_LINK_EN] |-> src[33] == wire_pin_in_i[1]) else $error("pin not chosen");
    no_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wire_pin_out_o == 2'b00) else $error("wire pin drives high");
    od_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wire_pin_oe_n_o[1] == !cfg_reg[`CMR_BIT_WIRE1_OD]) else $error("enable wrong");
    virt_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        virt_wr_i && virt_addr_i == `CMR_VIRT_REG_ADDR && !cfg_load_i |=> virt_reg == $past(virt_wdata_i))
        else $error("virtual write lost");
    fast_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fast_pull_o) && !cfg_load_i |-> fast_pull_o [*4]) else $error("strong pull too short");
    cmp_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
        src[59:56] == {slow_comparator_i, fast_comparator_i}) else $error("comparator map");
    fast_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(fast_pull_o));
    virt_c: cover property (@(posedge clk_i) disable iff (rst_i) virt_wr_i && virt_addr_i == 8'h4C);
    load_c: cover property (@(posedge clk_i) disable iff (rst_i) cfg_load_i ##1 cfg_valid_o);
endmodule // cmr_router
`default_nettype wire

/* File: bench/cmr_cells_model.sv */
// Stand-in for the macrocells and pins that feed the router's source lines.
// Assumes the bench gives the wanted level of every source code on want_i.
`default_nettype none
module cmr_cells_model (
    input  wire logic [63:0] want_i,      // Wanted level per source code
    input  wire logic [1:0]  wire_out_i,  // Router drive level of two-wire pins
    input  wire logic [1:0]  wire_oe_n_i, // Low while the router drives a pin
    output logic      [31:1] lut_o,       // Logic cell outputs
    output logic             rip_o,       // Ripple counter third output
    output logic             lut4_o,      // Four-input cell output
    output logic             dly_o,       // Delay edge output
    output logic             flt_o,       // Filter edge output
    output logic             gpi_o,       // Input-only pin level
    output logic      [9:2]  gpio_o,      // Two-way pin levels
    output logic      [1:0]  wire_in_o,   // Two-wire pin wire levels
    output logic      [2:0]  osc_a_o,     // Oscillator first outputs
    output logic      [1:0]  osc_b_o,     // Oscillator second outputs
    output logic      [1:0]  fast_o,      // High-speed comparators
    output logic      [1:0]  slow_o,      // Low-power comparators
    output logic             por_o        // Power-on reset output
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each source mirrors one bit of the wanted pattern
    assign lut_o   = want_i[31:1];
    assign rip_o   = want_i[40];
    assign lut4_o  = want_i[41];
    assign dly_o   = want_i[42];
    assign flt_o   = want_i[43];
    assign gpi_o   = want_i[44];
    assign gpio_o  = want_i[52:45];
    assign osc_a_o = want_i[55:53];
    assign fast_o  = want_i[57:56];
    assign slow_o  = want_i[59:58];
    assign osc_b_o = want_i[61:60];
    assign por_o   = want_i[62];
    // Wire resolves pull-up against an NMOS pull-down; a high drive is never honoured
    assign wire_in_o[0] = (!wire_oe_n_i[0] && !wire_out_i[0]) ? 1'b0 : want_i[32];
    assign wire_in_o[1] = (!wire_oe_n_i[1] && !wire_out_i[1]) ? 1'b0 : want_i[33];
endmodule // cmr_cells_model
`default_nettype wire

/* File: bench/cmr_router_test.sv */
// Self-checking bench for the router: loads store images, pokes the virtual byte, checks outputs.
// Assumes the design sources under src/ and the cells model are compiled first.
`default_nettype none
`define CMR_CHECK(g, e) check_val(128'(g), 128'(e))
module cmr_router_test;
    import cmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FPC = 4;                  // Short strong-pull phase keeps the run brief
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [2047:0]     cfg_data = '0;        // Store image on the pins
    logic              cfg_load = 1'b0;
    logic              virt_wr = 1'b0;
    logic [7:0]        virt_addr = 8'h4C;
    logic [7:0]        virt_wdata = 8'h00;
    logic [63:0]       want = 64'h5A3C_96F0_0FF0_C3A5; // Source pattern
    logic [31:1]       lut; logic rip, lut4, dly, flt, gpi, por;
    logic [9:2]        gpio; logic [2:0] osc_a; logic [1:0] osc_b, fcmp, scmp, win;
    logic [7:0]        rdata;
    logic [95:0]       dst;
    logic              valid, fpull;
    logic [1:0]        wout, woe_n;
    cmr_in_mode_t      m0, m1;
    logic [11:0]       pup;
    cmr_pull_val_t [11:0] pval;
    logic [2047:0]     img;                  // Image under test
    int                errors = 0;
    int                cmp_count = 0;
    int                n;
    always #5 clk_i = ~clk_i;
    cmr_cells_model cmr_cells_model_inst (.want_i(want), .wire_out_i(wout), .wire_oe_n_i(woe_n),
        .lut_o(lut), .rip_o(rip), .lut4_o(lut4), .dly_o(dly), .flt_o(flt), .gpi_o(gpi), .gpio_o(gpio),
        .wire_in_o(win), .osc_a_o(osc_a), .osc_b_o(osc_b), .fast_o(fcmp), .slow_o(scmp), .por_o(por));
    cmr_router #(.FAST_PULL_CYC(FPC)) cmr_router_inst (.clk_i(clk_i), .rst_i(rst_i), .cfg_data_i(cfg_data),
        .cfg_load_i(cfg_load), .lut_out_i(lut), .ripple_out2_i(rip), .lut4_out_i(lut4), .dly_edge_i(dly),
        .flt_edge_i(flt), .input_only_pin_i(gpi), .gpio_in_i(gpio), .wire_pin_in_i(win), .osc_out_a_i(osc_a),
        .osc_out_b_i(osc_b), .fast_comparator_i(fcmp), .slow_comparator_i(scmp), .por_i(por),
        .virt_wr_i(virt_wr), .virt_addr_i(virt_addr), .virt_wdata_i(virt_wdata), .virt_rdata_o(rdata),
        .dst_o(dst), .cfg_valid_o(valid), .wire_pin_out_o(wout), .wire_pin_oe_n_o(woe_n),
        .wire0_mode_o(m0), .wire1_mode_o(m1), .pull_up_o(pup), .pull_val_o(pval), .fast_pull_o(fpull));
    // Compare and count; four-state, so an unknown matches only an unknown in the expected value
    task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Expected destination lines worked out from image, pattern and virtual byte
    function automatic logic [95:0] exp_dst(input logic [2047:0] c, input logic [63:0] w, input logic [7:0] v);
        logic [63:0] s;
        logic [95:0] e;
        s = w;
        s[0] = 1'b0;
        s[63] = 1'b1;
        s[32] = c[2032] ? v[0] : (c[790] ? 1'b0 : w[32]);
        s[33] = c[2032] ? v[1] : (c[796] ? 1'b0 : w[33]);
        s[39:34] = v[7:2];
        for (int d = 0; d < 96; d++) e[d] = s[c[6*d +: 6]];
        return e;
    endfunction
    // One-cycle load pulse; outputs settle after the taking edge
    task automatic do_load(input logic [2047:0] c);
        @(posedge clk_i);
        cfg_data <= c;
        cfg_load <= 1'b1;
        @(posedge clk_i);
        cfg_load <= 1'b0;
        #1;
    endtask
    // Link write, then address back on the virtual byte and one cycle for read data
    task automatic link_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        virt_wr <= 1'b1; virt_addr <= a; virt_wdata <= d;
        @(posedge clk_i);
        virt_wr <= 1'b0; virt_addr <= 8'h4C;
        @(posedge clk_i);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        // Reset: nothing loaded, pins released
        repeat (2) @(posedge clk_i);
        #1;
        `CMR_CHECK(dst, 96'h0);
        `CMR_CHECK({valid, woe_n}, 3'b011);
        @(posedge clk_i);
        rst_i <= 1'b0;
        $display("test reset done");
        // Routing: destination d picks code d mod 64, so all 64 codes are exercised
        img = '0;
        for (int d = 0; d < 96; d++) img[6*d +: 6] = 6'(d % 64);
        img[615:608] = 8'hA5;
        do_load(img);
        @(posedge clk_i);
        #1;
        `CMR_CHECK(dst, exp_dst(img, want, 8'hA5));
        `CMR_CHECK({valid, fpull, woe_n, rdata}, {4'b1011, 8'hA5});
        want = ~want;
        #1;
        `CMR_CHECK(dst, exp_dst(img, want, 8'hA5));
        $display("test routing done");
        // Link mode, open-drain pins, modes, pulls and strong power-up pull
        img[2032] = 1'b1; img[790] = 1'b1; img[796] = 1'b1; img[778] = 1'b1;
        img[785:784] = 2'h2; img[793:792] = 2'h1;
        for (int p = 0; p < 12; p++) img[1000+3*p +: 3] = p[0] ? 3'h0 : 3'h7;
        do_load(img);
        n = 0;
        while (fpull === 1'b1 && n < 50) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CMR_CHECK(n, FPC);
        `CMR_CHECK({woe_n, wout}, 4'h0);
        `CMR_CHECK({m0, m1}, {CMR_IN_LOWV, CMR_IN_SCHMITT});
        `CMR_CHECK({pup, 24'(pval)}, {12'h555, 24'h333333});
        `CMR_CHECK(dst, exp_dst(img, want, 8'hA5));
        link_wr(8'h4C, 8'h3C);
        `CMR_CHECK({rdata, dst}, {8'h3C, exp_dst(img, want, 8'h3C)});
        link_wr(8'h4D, 8'hFF);
        `CMR_CHECK({rdata, dst}, {8'h3C, exp_dst(img, want, 8'h3C)});
        // Load and link write in one cycle: the load wins and restarts the strong pull
        @(posedge clk_i);
        virt_wr <= 1'b1; virt_wdata <= 8'hFF;
        do_load(img);
        virt_wr <= 1'b0;
        `CMR_CHECK(fpull, 1'b1);
        @(posedge clk_i);
        #1;
        `CMR_CHECK({rdata, dst}, {8'hA5, exp_dst(img, want, 8'hA5)});
        $display("test link done");
        give_verdict();
    end
endmodule // cmr_router_test
`default_nettype wire
